/* File: bsl_top.sv */
`timescale 1ns/1ps
`default_nettype none
module bsl_top
   import bsl_pkg::*;
(
   // clock and reset
   input  wire logic               i_core_clk,
   input  wire logic               i_rst,
   input  wire logic               i_enable,
   // strap pins: driven level and whether anything drives it
   input  wire logic [STRAP_W-1:0] i_pin_level,
   input  wire logic [STRAP_W-1:0] i_pin_driven,
   // firmware override
   input  wire logic               i_ovr_ldo_we,
   input  wire logic               i_ovr_ldo_1v8,
   input  wire logic               i_ovr_sdio_we,
   input  wire logic               i_ovr_smp_rise,
   input  wire logic               i_ovr_out_rise,
   // status and configuration
   output logic [STRAP_W-1:0]      o_strap_value,
   output logic                    o_pull_enable,
   output logic                    o_pin_normal,
   output logic                    o_ldo_1v8,
   output bsl_boot_t               o_boot_mode,
   output logic                    o_uart0_log_en,
   output logic                    o_sdio_smp_rise,
   output logic                    o_sdio_out_rise
);
   bsl_state_t         state;
   bsl_state_t         next_state;
   logic [STRAP_W-1:0] strap;
   logic [STRAP_W-1:0] pin_seen;
   logic               ldo_1v8;
   logic               smp_rise;
   logic               out_rise;
   logic               dec_ldo;
   logic               dec_smp;
   logic               dec_out;
   logic               dec_log;
   bsl_boot_t          dec_boot;
   bsl_strap_if        sif ();

   // undriven pins fall to their weak pull while in reset
   for (genvar b = 0; b < STRAP_W; b++)
   begin : g_pin
      assign pin_seen[b] = i_pin_driven[b] ? i_pin_level[b] : STRAP_PULL[b];
   end

   // disabled holds the chip in reset; the latch stays open meanwhile
   wire in_reset = i_rst | ~i_enable;
   assign next_state = in_reset ? BSL_OPEN : BSL_HELD;

   always_ff @(posedge i_core_clk)
   begin
      state <= next_state;
   end

   // transparent in reset, frozen from the release edge on
   always_ff @(posedge i_core_clk)
   begin
      if (in_reset)
      begin
         strap <= pin_seen;
      end
   end

   assign sif.strap     = strap;
   assign o_strap_value = strap;
   assign o_pull_enable = in_reset;
   assign o_pin_normal  = ~in_reset;

   bsl_decode u_dec
   (
      .s          (sif),
      .o_ldo_1v8  (dec_ldo),
      .o_boot     (dec_boot),
      .o_log_en   (dec_log),
      .o_smp_rise (dec_smp),
      .o_out_rise (dec_out)
   );

   // strap choice applies through reset; firmware may change it afterwards
   always_ff @(posedge i_core_clk)
   begin
      if (in_reset)
      begin
         ldo_1v8  <= pin_seen[BIT_LDO];
         smp_rise <= pin_seen[BIT_LOG_TIME];
         out_rise <= pin_seen[BIT_SDIO_EDGE];
      end
      else
      begin
         if (i_ovr_ldo_we)
         begin
            ldo_1v8 <= i_ovr_ldo_1v8;
         end
         else if (state == BSL_OPEN)
         begin
            ldo_1v8 <= dec_ldo;
         end
         if (i_ovr_sdio_we)
         begin
            smp_rise <= i_ovr_smp_rise;
            out_rise <= i_ovr_out_rise;
         end
         else if (state == BSL_OPEN)
         begin
            smp_rise <= dec_smp;
            out_rise <= dec_out;
         end
      end
   end

   assign o_ldo_1v8       = ldo_1v8;
   assign o_boot_mode     = dec_boot;
   assign o_uart0_log_en  = dec_log;
   assign o_sdio_smp_rise = smp_rise;
   assign o_sdio_out_rise = out_rise;
endmodule
`default_nettype wire

/* File: bsl_pkg.sv */
package bsl_pkg;
   localparam int unsigned STRAP_W       = 5;
   // bit positions inside the strap value word
   localparam int unsigned BIT_LDO       = 0;
   localparam int unsigned BIT_BOOT_SEL  = 1;
   localparam int unsigned BIT_DL_QUAL   = 2;
   localparam int unsigned BIT_LOG_TIME  = 3;
   localparam int unsigned BIT_SDIO_EDGE = 4;
   // weak pull levels: 1 = pull-up, 0 = pull-down
   localparam logic [4:0]  STRAP_PULL    = 5'h1a;
   localparam logic [4:0]  STRAP_RESET   = 5'h1a;
   typedef enum logic [2:0]
   {
      BSL_OPEN   = 3'h1,
      BSL_HELD   = 3'h2,
      BSL_OFF    = 3'h4
   } bsl_state_t;
   typedef enum logic [1:0]
   {
      BSL_BOOT_SPI      = 2'h1,
      BSL_BOOT_DOWNLOAD = 2'h2,
      BSL_BOOT_UNDEF    = 2'h0
   } bsl_boot_t;
endpackage

/* File: bsl_strap_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface bsl_strap_if;
   import bsl_pkg::*;
   logic [STRAP_W-1:0] strap;
   modport src (output strap);
   modport dst (input strap);
endinterface
`default_nettype wire

/* File: bsl_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module bsl_decode
   import bsl_pkg::*;
(
   bsl_strap_if.dst   s,
   output logic       o_ldo_1v8,
   output bsl_boot_t  o_boot,
   output logic       o_log_en,
   output logic       o_smp_rise,
   output logic       o_out_rise
);
   assign o_ldo_1v8  = s.strap[BIT_LDO];
   assign o_boot     = s.strap[BIT_BOOT_SEL] ? BSL_BOOT_SPI
                     : (!s.strap[BIT_DL_QUAL] ? BSL_BOOT_DOWNLOAD : BSL_BOOT_UNDEF);
   assign o_log_en   = s.strap[BIT_LOG_TIME];
   assign o_smp_rise = s.strap[BIT_LOG_TIME];
   assign o_out_rise = s.strap[BIT_SDIO_EDGE];
endmodule
`default_nettype wire

/* File: bsl_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module bsl_top_assertions
   import bsl_pkg::*;
(
   input wire logic               i_core_clk, i_rst, i_enable, i_ovr_ldo_we, i_ovr_ldo_1v8,
   input wire logic               i_ovr_sdio_we, i_ovr_smp_rise, i_ovr_out_rise,
   input wire logic [STRAP_W-1:0] i_pin_level, i_pin_driven, o_strap_value,
   input wire logic               o_pull_enable, o_pin_normal, o_ldo_1v8, o_uart0_log_en,
   input wire logic               o_sdio_smp_rise, o_sdio_out_rise,
   input wire bsl_boot_t          o_boot_mode
);
   wire       run = !i_rst && i_enable;
   wire [4:0] pin = (i_pin_level & i_pin_driven) | (STRAP_PULL & ~i_pin_driven);
   wire [4:0] v   = o_strap_value;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!run);
   sequence released_s; run ##1 run; endsequence
   strap_hold_a: assert property (released_s |=> $stable(v)) else $error("strap moved");
   strap_catch_a: assert property (disable iff (1'b0) !run |=> v == $past(pin))
      else $error("strap catch");
   pull_state_a: assert property (disable iff (1'b0) o_pull_enable == !run && o_pin_normal == run)
      else $error("pull state");
   boot_decode_a: assert property (o_boot_mode == (v[1] ? BSL_BOOT_SPI :
      v[2] ? BSL_BOOT_UNDEF : BSL_BOOT_DOWNLOAD)) else $error("boot mode");
   log_line_a: assert property (o_uart0_log_en == v[3]) else $error("log enable");
   strap_cfg_a: assert property ($rose(run) |-> o_ldo_1v8 == v[0] && o_sdio_smp_rise == v[3]
      && o_sdio_out_rise == v[4]) else $error("strap config");
   ldo_write_a: assert property (i_ovr_ldo_we |=> o_ldo_1v8 == $past(i_ovr_ldo_1v8))
      else $error("ldo write");
   sdio_write_a: assert property (i_ovr_sdio_we |=> o_sdio_smp_rise == $past(i_ovr_smp_rise)
      && o_sdio_out_rise == $past(i_ovr_out_rise)) else $error("sdio write");
endmodule
`default_nettype wire

/* File: bsl_strap_drv.sv */
`timescale 1ns/1ps
`default_nettype none
module bsl_strap_drv
   import bsl_pkg::*;
(
   input  wire logic               i_clk,
   input  wire logic [STRAP_W-1:0] i_want, i_hold,
   output wire logic [STRAP_W-1:0] o_level, o_driven
);
   logic [STRAP_W-1:0] tog = '0;
   // a released pin keeps toggling so a stale level never passes for a driven one
   always_ff @(posedge i_clk) tog <= ~tog;
   assign o_level  = (i_want & i_hold) | (tog & ~i_hold);
   assign o_driven = i_hold;
endmodule
`default_nettype wire

/* File: bsl_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bsl_top_tb;
   import bsl_pkg::*;
   logic clk = 0, rst = 1, en = 1, lw = 0, ll = 0, sw = 0, sr = 0, so = 0;
   logic [4:0] want = 0, hold = 0, lv, dv, v, e;
   logic ldo, pe, pn, lg, smp, outr;
   bsl_boot_t boot;
   int mismatches = 0, tests_run = 0;
   initial forever #20 clk = ~clk;
   bsl_strap_drv u_bsl_strap_drv (.i_clk(clk), .i_want(want), .i_hold(hold), .o_level(lv),
      .o_driven(dv));
   bsl_top u_bsl_top (.i_core_clk(clk), .i_rst(rst), .i_enable(en), .i_pin_level(lv),
      .i_pin_driven(dv), .i_ovr_ldo_we(lw), .i_ovr_ldo_1v8(ll), .i_ovr_sdio_we(sw),
      .i_ovr_smp_rise(sr), .i_ovr_out_rise(so), .o_strap_value(v), .o_pull_enable(pe),
      .o_pin_normal(pn), .o_ldo_1v8(ldo), .o_boot_mode(boot), .o_uart0_log_en(lg),
      .o_sdio_smp_rise(smp), .o_sdio_out_rise(outr));
   task automatic chk(string n, logic [4:0] x, logic [4:0] g);
      tests_run++;
      if (g !== x)
      begin
         mismatches++;
         $display("[FAIL] %s exp %h got %h", n, x, g);
      end
   endtask
   task automatic finish_test;
      if (mismatches == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      void'($urandom(40991));
      repeat (20) @(negedge clk);
      for (int i = 0; i < 40; i++)
      begin
         // first two passes: all pins floating, then all driven
         want = (i == 1) ? 5'h00 : 5'($urandom);
         hold = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
         rst = !i[0];
         en = !i[0] ? 1'b1 : 1'b0;
         repeat (2) @(negedge clk);
         chk("pull", 5'h02, {pe, pn});
         e = (want & hold) | (STRAP_PULL & ~hold);
         rst = 0;
         en = 1;
         @(negedge clk);
         chk("strap", e, v);
         chk("pins", 5'h01, {pe, pn});
         chk("boot", e[1] ? BSL_BOOT_SPI : e[2] ? BSL_BOOT_UNDEF : BSL_BOOT_DOWNLOAD, boot);
         chk("cfg", {e[4:3], e[3], e[0]}, {outr, smp, lg, ldo});
         want = ~want;
         hold = 5'h1f;
         lw = 1;
         sw = 1;
         {ll, sr, so} = 3'($urandom);
         @(negedge clk);
         {ll, sr, so} = ~{ll, sr, so};
         @(negedge clk);
         lw = 0;
         sw = 0;
         @(negedge clk);
         chk("ovr", {ll, sr, so}, {ldo, smp, outr});
         chk("hold", e, v);
      end
      finish_test();
   end
   initial
   begin
      #50us;
      mismatches++;
      finish_test();
   end
endmodule
bind bsl_top bsl_top_assertions u_bsl_top_assertions (.*);
`default_nettype wire
